// ===== hdl/csf_pkg.sv
// Purpose: shared constants for the charger status and fault register bank
// Assumes: 8-bit register address space, 8-bit registers
// Notes: every offset, field position and reset value lives here
package csf_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_REGS = 3;

    // register offsets
    localparam logic [7:0] OFS_PATH_ADC_TIMER = 8'h1e;
    localparam logic [7:0] OFS_THERM_ZONE = 8'h1f;
    localparam logic [7:0] OFS_PROT_FAULT = 8'h20;

    // register index inside the bank
    localparam int unsigned IDX_PATH_ADC_TIMER = 0;
    localparam int unsigned IDX_THERM_ZONE = 1;
    localparam int unsigned IDX_PROT_FAULT = 2;

    // reset value shared by all three registers
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // path, adc and timer status fields
    localparam int unsigned BIT_INPUT2_FET_PAIR_FITTED = 7;
    localparam int unsigned BIT_INPUT1_FET_PAIR_FITTED = 6;
    localparam int unsigned BIT_ADC_DONE = 5;
    localparam int unsigned BIT_MIN_SYSTEM_REG_ACTIVE = 4;
    localparam int unsigned BIT_FAST_TIMER_EXPIRED = 3;
    localparam int unsigned BIT_TRICKLE_TIMER_EXPIRED = 2;
    localparam int unsigned BIT_PRE_TIMER_EXPIRED = 1;
    localparam logic [7:0] MASK_PATH_ADC_TIMER = 8'hfe;

    // thermistor zone fields
    localparam int unsigned BIT_THERM_COLD_ZONE = 3;
    localparam int unsigned BIT_THERM_COOL_ZONE = 2;
    localparam int unsigned BIT_THERM_WARM_ZONE = 1;
    localparam int unsigned BIT_THERM_HOT_ZONE = 0;
    localparam logic [7:0] MASK_THERM_ZONE = 8'h0f;

    // protection fault fields; bit 0 is kept elsewhere in the device
    localparam int unsigned BIT_DISCHARGE_CURRENT_REG = 7;
    localparam int unsigned BIT_BUS_INPUT_OVERVOLTAGE = 6;
    localparam int unsigned BIT_BATTERY_OVERVOLTAGE = 5;
    localparam int unsigned BIT_INPUT_OVERCURRENT = 4;
    localparam int unsigned BIT_BATTERY_OVERCURRENT = 3;
    localparam int unsigned BIT_CONVERTER_OVERCURRENT = 2;
    localparam int unsigned BIT_SECOND_INPUT_OVERVOLTAGE = 1;
    localparam logic [7:0] MASK_PROT_FAULT = 8'hfe;
endpackage

// ===== hdl/csf_status_hold.sv
// Purpose: one 8-bit status register that follows its detector vector
// Assumes: detector vector is synchronous to ref_clk
// Notes: bits outside keep_mask are forced to zero on every load
module csf_status_hold (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] keep_mask,
    input wire logic [7:0] status_d,
    output logic [7:0] status_q
);
    // reserved positions never store anything, so they always read zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            status_q <= csf_pkg::STATUS_RESET;
        end else if (ce) begin
            status_q <= status_d & keep_mask;
        end
    end
endmodule

// ===== hdl/csf_status_regs.sv
// Purpose: read-only charger status and protection fault register bank
// Assumes: detector inputs and the register port are synchronous to ref_clk
// Notes: register port is the internal side of the serial control bus slave
module csf_status_regs (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // register access port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    output logic reg_err_q,
    // power path detectors
    input wire logic input2_fet_pair_fitted,
    input wire logic input1_fet_pair_fitted,
    // adc sequencing
    input wire logic adc_oneshot_mode,
    input wire logic adc_conv_start,
    input wire logic adc_conv_done,
    // system regulation
    input wire logic forward_mode,
    input wire logic vbat_below_sysmin,
    // safety timers
    input wire logic fast_timer_expired,
    input wire logic trickle_timer_expired,
    input wire logic pre_timer_expired,
    // thermistor comparators
    input wire logic therm_cold_zone,
    input wire logic therm_cool_zone,
    input wire logic therm_warm_zone,
    input wire logic therm_hot_zone,
    // protection detectors
    input wire logic discharge_current_reg,
    input wire logic bus_input_overvoltage,
    input wire logic battery_overvoltage,
    input wire logic input_overcurrent,
    input wire logic battery_overcurrent,
    input wire logic converter_overcurrent,
    input wire logic second_input_overvoltage,
    // live copies of the three registers
    output logic [7:0] path_adc_timer_status_q,
    output logic [7:0] thermistor_zone_status_q,
    output logic [7:0] protection_fault_status_q
);

    // one index per mapped offset, NUM_REGS when nothing matches
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        logic [1:0] idx;
        idx = 2'(csf_pkg::NUM_REGS);
        case (addr)
            csf_pkg::OFS_PATH_ADC_TIMER: idx = 2'(csf_pkg::IDX_PATH_ADC_TIMER);
            csf_pkg::OFS_THERM_ZONE: idx = 2'(csf_pkg::IDX_THERM_ZONE);
            csf_pkg::OFS_PROT_FAULT: idx = 2'(csf_pkg::IDX_PROT_FAULT);
            default: idx = 2'(csf_pkg::NUM_REGS);
        endcase
        return idx;
    endfunction

    // true for the three bank offsets; shared by the error flag
    function automatic logic is_mapped(input logic [7:0] addr);
        return reg_index(addr) != 2'(csf_pkg::NUM_REGS);
    endfunction

    // next values, reserved masks and stored words, one slot per register
    logic adc_done_q;
    logic adc_done_d;
    logic [7:0] path_adc_timer_d;
    logic [7:0] therm_zone_d;
    logic [7:0] prot_fault_d;
    logic [7:0] status_d [csf_pkg::NUM_REGS];
    logic [7:0] keep_mask [csf_pkg::NUM_REGS];
    logic [7:0] status_q [csf_pkg::NUM_REGS];
    logic [7:0] read_mux;
    logic [1:0] rd_idx;

    // adc completion is sticky until the next conversion or leaving one-shot;
    // a completion in the same cycle as a conversion start wins so it is never lost;
    // leaving one-shot clears the bit, so a stale completion never shows
    always_comb begin
        adc_done_d = adc_done_q;
        if (!adc_oneshot_mode || adc_conv_start) begin
            adc_done_d = 1'b0;
        end
        if (adc_oneshot_mode && adc_conv_done) begin
            adc_done_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            adc_done_q <= 1'b0;
        end else if (ce) begin
            adc_done_q <= adc_done_d;
        end
    end

    // first status register: power path, adc, regulation and timers
    always_comb begin
        path_adc_timer_d = csf_pkg::STATUS_RESET;
        path_adc_timer_d[csf_pkg::BIT_INPUT2_FET_PAIR_FITTED] = input2_fet_pair_fitted;
        path_adc_timer_d[csf_pkg::BIT_INPUT1_FET_PAIR_FITTED] = input1_fet_pair_fitted;
        path_adc_timer_d[csf_pkg::BIT_ADC_DONE] = adc_done_d;
        // outside forward mode the regulation indication is held clear
        path_adc_timer_d[csf_pkg::BIT_MIN_SYSTEM_REG_ACTIVE] =
            forward_mode & vbat_below_sysmin;
        path_adc_timer_d[csf_pkg::BIT_FAST_TIMER_EXPIRED] = fast_timer_expired;
        path_adc_timer_d[csf_pkg::BIT_TRICKLE_TIMER_EXPIRED] = trickle_timer_expired;
        path_adc_timer_d[csf_pkg::BIT_PRE_TIMER_EXPIRED] = pre_timer_expired;
    end

    // thermistor zones; comparators may overlap, each bit is reported as is
    always_comb begin
        therm_zone_d = csf_pkg::STATUS_RESET;
        therm_zone_d[csf_pkg::BIT_THERM_COLD_ZONE] = therm_cold_zone;
        therm_zone_d[csf_pkg::BIT_THERM_COOL_ZONE] = therm_cool_zone;
        therm_zone_d[csf_pkg::BIT_THERM_WARM_ZONE] = therm_warm_zone;
        therm_zone_d[csf_pkg::BIT_THERM_HOT_ZONE] = therm_hot_zone;
    end

    // protection faults; bit 0 belongs to logic outside this bank
    always_comb begin
        prot_fault_d = csf_pkg::STATUS_RESET;
        prot_fault_d[csf_pkg::BIT_DISCHARGE_CURRENT_REG] = discharge_current_reg;
        prot_fault_d[csf_pkg::BIT_BUS_INPUT_OVERVOLTAGE] = bus_input_overvoltage;
        prot_fault_d[csf_pkg::BIT_BATTERY_OVERVOLTAGE] = battery_overvoltage;
        prot_fault_d[csf_pkg::BIT_SECOND_INPUT_OVERVOLTAGE] =
            second_input_overvoltage;
        prot_fault_d[csf_pkg::BIT_INPUT_OVERCURRENT] = input_overcurrent;
        prot_fault_d[csf_pkg::BIT_BATTERY_OVERCURRENT] = battery_overcurrent;
        prot_fault_d[csf_pkg::BIT_CONVERTER_OVERCURRENT] = converter_overcurrent;
    end

    // gather next values and reserved masks for the generate loop
    assign status_d[csf_pkg::IDX_PATH_ADC_TIMER] = path_adc_timer_d;
    assign status_d[csf_pkg::IDX_THERM_ZONE] = therm_zone_d;
    assign status_d[csf_pkg::IDX_PROT_FAULT] = prot_fault_d;
    assign keep_mask[csf_pkg::IDX_PATH_ADC_TIMER] = csf_pkg::MASK_PATH_ADC_TIMER;
    assign keep_mask[csf_pkg::IDX_THERM_ZONE] = csf_pkg::MASK_THERM_ZONE;
    assign keep_mask[csf_pkg::IDX_PROT_FAULT] = csf_pkg::MASK_PROT_FAULT;

    // one holding register per status word; reg_wdata never reaches them
    for (genvar g = 0; g < csf_pkg::NUM_REGS; g++) begin : g_hold
        csf_status_hold u_hold (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .ce(ce),
            .keep_mask(keep_mask[g]),
            .status_d(status_d[g]),
            .status_q(status_q[g])
        );
    end

    // live copies come straight from the holding flops, no extra stage
    assign path_adc_timer_status_q = status_q[csf_pkg::IDX_PATH_ADC_TIMER];
    assign thermistor_zone_status_q = status_q[csf_pkg::IDX_THERM_ZONE];
    assign protection_fault_status_q = status_q[csf_pkg::IDX_PROT_FAULT];

    // read select; unmapped offsets read zero
    assign rd_idx = reg_index(reg_addr);

    // registered words only, so read data trails the detectors by two edges
    always_comb begin
        case (rd_idx)
            2'(csf_pkg::IDX_PATH_ADC_TIMER): read_mux = status_q[csf_pkg::IDX_PATH_ADC_TIMER];
            2'(csf_pkg::IDX_THERM_ZONE): read_mux = status_q[csf_pkg::IDX_THERM_ZONE];
            2'(csf_pkg::IDX_PROT_FAULT): read_mux = status_q[csf_pkg::IDX_PROT_FAULT];
            default: read_mux = csf_pkg::READ_IDLE;
        endcase
    end

    // read data is held until the next read; a write returns no data
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata_q <= csf_pkg::READ_IDLE;
        end else if (ce && reg_rd_en) begin
            reg_rdata_q <= read_mux;
        end
    end

    // one-cycle answer to every read, mapped or not;
    // a frozen clock enable also freezes the pulse, so it may stand longer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rvalid_q <= 1'b0;
        end else if (ce) begin
            reg_rvalid_q <= reg_rd_en;
        end
    end

    // writes are dropped; flag them and unmapped reads for the bus slave
    // so it can decide whether to acknowledge, reg_wdata is ignored
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_err_q <= 1'b0;
        end else if (ce) begin
            reg_err_q <= reg_wr_en | (reg_rd_en & ~is_mapped(reg_addr));
        end
    end

    // write data has no destination in a read-only bank;
    // folding it keeps the port from being left unread
    logic wdata_unused;
    assign wdata_unused = ^reg_wdata;

endmodule

// ===== tb/csf_status_regs_props.sv
// Purpose: port checker for the charger status register bank
// Assumes: ce held high by the bench, detectors sampled on ref_clk
// Notes: takes a subset of the ports, the bench compares the rest
module csf_status_regs_props (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q,
    input wire logic reg_err_q,
    input wire logic input2_fet_pair_fitted,
    input wire logic input1_fet_pair_fitted,
    input wire logic adc_oneshot_mode,
    input wire logic adc_conv_done,
    input wire logic forward_mode,
    input wire logic vbat_below_sysmin,
    input wire logic therm_cold_zone,
    input wire logic therm_hot_zone,
    input wire logic converter_overcurrent,
    input wire logic [7:0] path_adc_timer_status_q,
    input wire logic [7:0] thermistor_zone_status_q,
    input wire logic [7:0] protection_fault_status_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // read path: answer exactly one edge later, data from the live copy
    AST_RD_ANSWER: assert property (ce && reg_rd_en |=> reg_rvalid_q)
        else $error("read not answered");
    AST_RD_DATA: assert property (ce && reg_rd_en && reg_addr == csf_pkg::OFS_THERM_ZONE
        |=> reg_rdata_q == $past(thermistor_zone_status_q)) else $error("read data wrong");
    AST_WR_REFUSED: assert property (ce && reg_wr_en && !reg_rd_en
        |=> reg_err_q && !reg_rvalid_q) else $error("write not refused");
    AST_RESERVED: assert property (path_adc_timer_status_q[0] == 1'h0
        && thermistor_zone_status_q[7:4] == 4'h0) else $error("reserved bit set");
    // status bits follow their detectors with one edge of latency
    AST_FET: assert property (ce |=> path_adc_timer_status_q[7:6]
        == $past({input2_fet_pair_fitted, input1_fet_pair_fitted})) else $error("fet bits");
    AST_SYSMIN: assert property (ce |=> path_adc_timer_status_q[4]
        == $past(forward_mode && vbat_below_sysmin)) else $error("sysmin bit");
    AST_ADC_SET: assert property (ce && adc_oneshot_mode && adc_conv_done
        |=> path_adc_timer_status_q[5]) else $error("adc done not set");
    AST_ADC_MODE: assert property (ce && !adc_oneshot_mode
        |=> !path_adc_timer_status_q[5]) else $error("adc done outside one-shot");
    AST_THERM: assert property (ce |=>
        thermistor_zone_status_q[3] == $past(therm_cold_zone)
        && thermistor_zone_status_q[0] == $past(therm_hot_zone)) else $error("zone bits");
    AST_CONV: assert property (ce |=> protection_fault_status_q[2]
        == $past(converter_overcurrent)) else $error("converter bit");
    AST_RESET: assert property (disable iff (1'h0) !resetn
        |=> path_adc_timer_status_q == 8'h00 && thermistor_zone_status_q == 8'h00
        && protection_fault_status_q == 8'h00 && !reg_rvalid_q) else $error("reset value");
    cover property (reg_rvalid_q && reg_err_q);
    cover property (path_adc_timer_status_q[5]);
    cover property (reg_err_q && !reg_rvalid_q);
endmodule

bind csf_status_regs csf_status_regs_props props_u (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .reg_addr(reg_addr),
    .reg_rd_en(reg_rd_en),
    .reg_wr_en(reg_wr_en),
    .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q),
    .reg_err_q(reg_err_q),
    .input2_fet_pair_fitted(input2_fet_pair_fitted),
    .input1_fet_pair_fitted(input1_fet_pair_fitted),
    .adc_oneshot_mode(adc_oneshot_mode),
    .adc_conv_done(adc_conv_done),
    .forward_mode(forward_mode),
    .vbat_below_sysmin(vbat_below_sysmin),
    .therm_cold_zone(therm_cold_zone),
    .therm_hot_zone(therm_hot_zone),
    .converter_overcurrent(converter_overcurrent),
    .path_adc_timer_status_q(path_adc_timer_status_q),
    .thermistor_zone_status_q(thermistor_zone_status_q),
    .protection_fault_status_q(protection_fault_status_q)
);

// ===== tb/csf_host_model.sv
// Purpose: serial bus host seen from the register port
// Assumes: one access at a time, answer one edge after the request
// Notes: released address and data show the inverse of the last value
module csf_host_model (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic reg_rd_en,
    output logic reg_wr_en,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q,
    input wire logic reg_err_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_addr, reg_rd_en, reg_wr_en, reg_wdata} = 18'h0_0000;
    end
    // request held over one rising edge, answer taken the edge after
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] wd,
        output logic [7:0] d, output logic v, output logic e);
        @(negedge ref_clk);
        {reg_addr, reg_rd_en, reg_wr_en, reg_wdata} = {a, !wr, wr, wd};
        @(negedge ref_clk);
        {reg_addr, reg_rd_en, reg_wr_en, reg_wdata} = {~a, 2'h0, ~wd}; // no stale value
        // the answer pulse stands one cycle only, so take it at this edge
        @(posedge ref_clk);
        {d, v, e} = {reg_rdata_q, reg_rvalid_q, reg_err_q};
    endtask
endmodule

// ===== tb/charger_status_fault_regs_bench.sv
// Purpose: self-checking bench for the charger status register bank
// Assumes: ce tied high, detectors change on the falling edge
// Notes: adc start and done pulse in corner cases and sit as random levels
module charger_status_fault_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic ce = 1'h1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, d;
    logic reg_rd_en, reg_wr_en, reg_rvalid_q, reg_err_q, rv, er, adc_exp;
    logic input2_fet_pair_fitted, input1_fet_pair_fitted, adc_oneshot_mode, adc_conv_start;
    logic adc_conv_done, forward_mode, vbat_below_sysmin, fast_timer_expired;
    logic trickle_timer_expired, pre_timer_expired, therm_cold_zone, therm_cool_zone;
    logic therm_warm_zone, therm_hot_zone, discharge_current_reg, bus_input_overvoltage;
    logic battery_overvoltage, input_overcurrent, battery_overcurrent, converter_overcurrent;
    logic second_input_overvoltage;
    logic [7:0] path_adc_timer_status_q, thermistor_zone_status_q, protection_fault_status_q;
    logic [20:0] x;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int unsigned seed;
    always #20 ref_clk = ~ref_clk;
    csf_host_model host_u (.*);
    csf_status_regs dut_u (.*);
    // detector vector, bit 18 one-shot, 17 start, 16 done
    task automatic set_det(input logic [20:0] v);
        {input2_fet_pair_fitted, input1_fet_pair_fitted, adc_oneshot_mode, adc_conv_start,
         adc_conv_done, forward_mode, vbat_below_sysmin, fast_timer_expired,
         trickle_timer_expired, pre_timer_expired, therm_cold_zone, therm_cool_zone,
         therm_warm_zone, therm_hot_zone, discharge_current_reg, bus_input_overvoltage,
         battery_overvoltage, input_overcurrent, battery_overcurrent, converter_overcurrent,
         second_input_overvoltage} = v;
    endtask
    task automatic drive(input logic [20:0] v);
        @(negedge ref_clk);
        set_det(v);
    endtask
    function automatic logic [23:0] expect_regs(input logic [20:0] v, input logic adc);
        return {v[20:19], adc, v[15] & v[14], v[13:11], 1'h0, 4'h0, v[10:7], v[6:0], 1'h0};
    endfunction
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // one read access: the returned byte, then the answer pulse
    task automatic rd1(input string n, input logic [7:0] a, input logic [7:0] e);
        host_u.xfer(a, 1'h0, 8'h00, d, rv, er);
        chk(n, d, e);
        chk("answer", {6'h00, rv, er}, 8'h02);
    endtask
    // read the three registers back to back, one access each
    task automatic rd3(input logic [23:0] e);
        rd1("path reg", csf_pkg::OFS_PATH_ADC_TIMER, e[23:16]);
        rd1("therm reg", csf_pkg::OFS_THERM_ZONE, e[15:8]);
        rd1("fault reg", csf_pkg::OFS_PROT_FAULT, e[7:0]);
    endtask
    // one-shot held, a start or done pulse, then read bit 5
    task automatic adc_step(input logic [20:0] pulse, input logic e);
        drive(pulse);
        drive(21'h4_0000);
        rd3(expect_regs(21'h4_0000, e));
    endtask
    task automatic conclude();
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // hang guard, well above the roughly 500 cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        seed = $urandom(12640);
        set_det(21'h0_0000);
        repeat (20) @(negedge ref_clk);
        chk("in reset", path_adc_timer_status_q | protection_fault_status_q, 8'h00);
        resetn = 1'h1;
        rd3(24'h00_0000);
        adc_step(21'h5_0000, 1'h1);
        adc_step(21'h6_0000, 1'h0);
        adc_step(21'h7_0000, 1'h1);
        drive(21'h0_0000);
        rd3(expect_regs(21'h0_0000, 1'h0));
        // unmapped read and a write to a read-only place
        host_u.xfer(8'h21, 1'h0, 8'h00, d, rv, er);
        chk("unmapped", d, 8'h00);
        chk("unmapped answer", {6'h00, rv, er}, 8'h03);
        host_u.xfer(csf_pkg::OFS_THERM_ZONE, 1'h1, 8'hff, d, rv, er);
        chk("write", {6'h00, rv, er}, 8'h01);
        rd3(24'h00_0000);
        adc_exp = 1'h0;
        repeat (60) begin
            x = 21'($urandom);
            drive(x);
            // done held in one-shot sets the bit and beats a start held alongside
            if (x[18] && x[16]) begin
                adc_exp = 1'h1;
            end else if (!x[18] || x[17]) begin
                adc_exp = 1'h0;
            end
            rd3(expect_regs(x, adc_exp));
        end
        // mid-run reset with every detector raised must still clear the bank
        drive(21'h1f_ffff);
        resetn = 1'h0;
        repeat (2) @(negedge ref_clk);
        chk("mid reset", path_adc_timer_status_q | thermistor_zone_status_q, 8'h00);
        chk("mid reset fault", protection_fault_status_q, 8'h00);
        resetn = 1'h1;
        rd3(expect_regs(21'h1f_ffff, 1'h1));
        conclude();
    end
endmodule
